// *** core/shhrc_pkg.sv ***
/*
  Constants, widths and state encoding for the standby, hold, halt and
  reset controller. Assumes nothing beyond a SystemVerilog compiler.
*/
package shhrc_pkg;
  localparam int               WAIT_CNT_W        = 16;
  // Hold-release wait, in oscillator cycles
  localparam int               HOLD_WAIT_OSC_CYC = 16384;
  // The core clock is the oscillator itself
  localparam int               OSC_PER_CLK       = 1;
  localparam int               HOLD_WAIT_CLK     = HOLD_WAIT_OSC_CYC
                                                   / OSC_PER_CLK;
  localparam int               T0_W              = 12;
  localparam logic [T0_W-1:0]  T0_RESET_VAL      = 12'hFFC;
  localparam int               PORT_W            = 4;
  localparam int               NUM_RST_PORTS     = 3;
  localparam int               P3_IN_W           = 3;
  localparam int               INV_NUM           = 2;
  localparam int               PORT0_IDX         = 0;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_HOLD = 2'b10,
    ST_WAIT = 2'b11
  } shhrc_state_t;
endpackage

// *** core/shhrc_top.sv ***
/*
  Standby and reset controller of a 4-bit controller core: hold, halt,
  release wait, timer 0 preset, port and inverter drive in standby.
  Assumes pin inputs are synchronous to ref_clk and the core fetches only
  while cpu_run is high.
*/
// Contract
// - Hold instruction with standby pin low enters hold mode.
// - In hold, raising the standby pin restarts the processor.
// - Reset input is ignored while the standby pin is low.
// - After hold release wait 16384 oscillator cycles before running.
// - Reset and hold release both load timer 0 with FFC.
// - Hold turns port drivers off; halt keeps port outputs unchanged.
// - Inverter outputs off in hold, still operating in halt.
// - Each port 0 bit may separately release halt mode.
// - Reset drives ports 0, 1, 4 to mask-selected high or low.
// - Standby pin reads as port 3 bit 3 beside three other bits.
// - Oscillator stops in hold, keeps running in halt.
// - With standby pin high, reset input low resets the processor.
module shhrc_top
  import shhrc_pkg::*;
#(
  parameter logic [NUM_RST_PORTS-1:0] PORT_RST_LVL = 3'h7,
  parameter logic [WAIT_CNT_W-1:0]    HOLD_WAIT    =
                                        HOLD_WAIT_CLK[WAIT_CNT_W-1:0]
) (
  input  wire logic                                ref_clk,
  input  wire logic                                arst_n,
  input  wire logic                                reset_input_pin_n,
  input  wire logic                                standby_control_pin,
  input  wire logic                                hold_instr,
  input  wire logic                                halt_instr,
  input  wire logic [PORT_W-1:0]                   halt_release_en,
  input  wire logic [PORT_W-1:0]                   halt_release_port_bits,
  input  wire logic [P3_IN_W-1:0]                  port3_pins,
  input  wire logic [NUM_RST_PORTS-1:0]            port_wr_en,
  input  wire logic [NUM_RST_PORTS-1:0][PORT_W-1:0] port_wr_data,
  input  wire logic [INV_NUM-1:0]                  inv_in,
  output logic                                     cpu_reset,
  output logic                                     cpu_run,
  output logic                                     osc_run,
  output logic                                     hold_active,
  output logic                                     halt_active,
  output logic                                     timer0_load,
  output logic [T0_W-1:0]                          timer0_value,
  output logic [PORT_W-1:0]                        port3_read,
  output logic [NUM_RST_PORTS-1:0][PORT_W-1:0]     port_out,
  output logic [NUM_RST_PORTS-1:0]                 port_oe_n,
  output logic [INV_NUM-1:0]                       inv_out,
  output logic [INV_NUM-1:0]                       inv_oe_n
);
  logic                              rst_meta_reg;
  logic                              rst_n;
  shhrc_state_t                      state_reg;
  shhrc_state_t                      state_next;
  logic                              cpu_reset_reg;
  logic                              timer0_load_reg;
  logic [T0_W-1:0]                   timer0_value_reg;
  logic [PORT_W-1:0]                 port3_read_reg;
  logic [NUM_RST_PORTS-1:0][PORT_W-1:0] port_reg;
  logic [NUM_RST_PORTS-1:0]          port_oe_n_reg;
  logic [INV_NUM-1:0]                inv_out_reg;
  logic                              inv_off_reg;

  shhrc_wait_if wif ();

  // Reset release synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // A low standby pin masks the reset pin so a sagging supply in hold
  // cannot scramble the retained state
  wire logic pin_reset_w  = standby_control_pin &&
                            !reset_input_pin_n;
  wire logic hold_go_w    = (state_reg == ST_RUN) && hold_instr &&
                            !standby_control_pin;
  wire logic halt_go_w    = (state_reg == ST_RUN) && halt_instr && !hold_go_w;
  wire logic halt_wake_w  =
    |(halt_release_en & halt_release_port_bits);
  wire logic hold_wake_w  = (state_reg == ST_HOLD) &&
                            standby_control_pin;
  wire logic t0_load_w    = pin_reset_w || hold_wake_w;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (hold_go_w) begin
          state_next = ST_HOLD;
        end else if (halt_go_w) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (halt_wake_w) begin
          state_next = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (hold_wake_w) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wif.done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
    if (pin_reset_w) begin
      state_next = ST_RUN;
    end
  end

  assign wif.start = hold_wake_w && !pin_reset_w;
  assign wif.abort = pin_reset_w;

  shhrc_wait #(
    .WAIT_CYCLES (HOLD_WAIT)
  ) u_wait (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wif     (wif)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= ST_RUN;
      cpu_reset_reg    <= 1'b1;
      timer0_load_reg  <= 1'b1;
      timer0_value_reg <= T0_RESET_VAL;
      port3_read_reg   <= '0;
    end else begin
      state_reg        <= state_next;
      cpu_reset_reg    <= pin_reset_w;
      timer0_load_reg  <= t0_load_w;
      timer0_value_reg <= T0_RESET_VAL;
      port3_read_reg   <= {standby_control_pin, port3_pins};
    end
  end

  // Port latches; writes only land while the core runs, so halt and hold
  // keep the last value
  for (genvar p = 0; p < NUM_RST_PORTS; p++) begin : g_port
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        port_reg[p]      <= {PORT_W{PORT_RST_LVL[p]}};
        port_oe_n_reg[p] <= 1'b0;
      end else begin
        if (pin_reset_w) begin
          port_reg[p] <= {PORT_W{PORT_RST_LVL[p]}};
        end else if (port_wr_en[p] && (state_reg == ST_RUN)) begin
          port_reg[p] <= port_wr_data[p];
        end
        port_oe_n_reg[p] <= (state_next == ST_HOLD);
      end
    end
  end

  // Inverters keep working in halt; in hold the output is forced low and
  // released so the pin draws no current
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_out_reg <= '0;
      inv_off_reg <= 1'b0;
    end else begin
      inv_off_reg <= (state_next == ST_HOLD);
      inv_out_reg <= (state_next == ST_HOLD) ? '0 : ~inv_in;
    end
  end

  assign cpu_reset    = cpu_reset_reg;
  assign cpu_run      = (state_reg == ST_RUN) && !cpu_reset_reg;
  assign osc_run      = (state_reg != ST_HOLD);
  assign hold_active  = (state_reg == ST_HOLD);
  assign halt_active  = (state_reg == ST_HALT);
  assign timer0_load  = timer0_load_reg;
  assign timer0_value = timer0_value_reg;
  assign port3_read   = port3_read_reg;
  assign port_out     = port_reg;
  assign port_oe_n    = port_oe_n_reg;
  assign inv_out      = inv_out_reg;
  assign inv_oe_n     = {INV_NUM{inv_off_reg}};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_hold;
    (state_reg == ST_RUN) && hold_instr && !standby_control_pin &&
    !pin_reset_w;
  endsequence
  sequence s_wake;
    (state_reg == ST_HOLD) && standby_control_pin && reset_input_pin_n;
  endsequence

  AST_HOLD_ENTRY: assert property (
    s_enter_hold |=> hold_active && !osc_run)
    else $error("hold instruction did not enter hold");
  AST_HOLD_WAKE: assert property (
    s_wake |=> (state_reg == ST_WAIT) && !cpu_run ##1 wif.busy)
    else $error("raised standby pin did not start release");
  AST_RESET_MASKED: assert property (
    !standby_control_pin |=> !cpu_reset && !timer0_load)
    else $error("reset taken while standby pin low");
  AST_RESET_TAKEN: assert property (
    pin_reset_w |=> cpu_reset && (state_reg == ST_RUN) && !cpu_run)
    else $error("reset input not honoured");
  AST_WAIT_STALL: assert property (
    s_wake |=> !cpu_run [*8])
    else $error("fetch resumed during release wait");
  AST_T0_PRESET: assert property (
    ((state_reg == ST_HOLD) && standby_control_pin) || pin_reset_w |=>
      timer0_load && (timer0_value == T0_RESET_VAL))
    else $error("timer 0 preset missing");
  AST_HOLD_PORTS_OFF: assert property (
    hold_active |-> (&port_oe_n) && (&inv_oe_n) && (inv_out == '0))
    else $error("drivers left on in hold");
  AST_HALT_RETAIN: assert property (
    halt_active && $past(halt_active) |-> $stable(port_out) && !(|port_oe_n))
    else $error("port changed in halt");
  AST_HALT_INV: assert property (
    halt_active && $past(halt_active) |-> inv_out == ~$past(inv_in))
    else $error("inverter stopped in halt");
  AST_HALT_RELEASE: assert property (
    halt_active && halt_wake_w |=> cpu_run || cpu_reset)
    else $error("enabled port 0 bit did not release halt");
  AST_HALT_MASKED: assert property (
    halt_active && !halt_wake_w && !pin_reset_w |=> halt_active)
    else $error("halt released by disabled bit");
  AST_RST_LEVEL: assert property (
    pin_reset_w |=> port_out[PORT0_IDX] == {PORT_W{PORT_RST_LVL[PORT0_IDX]}})
    else $error("port 0 reset level wrong");
  AST_P3_READ: assert property (
    1'b1 |=> port3_read == {$past(standby_control_pin), $past(port3_pins)})
    else $error("port 3 read mismatch");
  AST_OSC_HALT: assert property (halt_active |-> osc_run)
    else $error("oscillator stopped in halt");
endmodule

// *** core/shhrc_wait.sv ***
/*
  Release wait counter: counts a fixed number of clocks after start.
  Assumes start is a single-cycle request; abort stays high while the controller takes a pin reset.
*/
module shhrc_wait
  import shhrc_pkg::*;
#(
  parameter logic [WAIT_CNT_W-1:0] WAIT_CYCLES = HOLD_WAIT_CLK[WAIT_CNT_W-1:0]
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  shhrc_wait_if.cnt  wif
);
  logic [WAIT_CNT_W-1:0] cnt_reg;
  logic                  busy_reg;
  wire  logic            last_w = busy_reg &&
                                  (cnt_reg == WAIT_CYCLES - 16'h0001);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (wif.abort) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (wif.start) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg  <= last_w ? '0 : cnt_reg + 16'h0001;
      busy_reg <= !last_w;
    end
  end

  assign wif.busy = busy_reg;
  assign wif.done = last_w;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_WAIT_FULL_COUNT: assert property (
    wif.done |-> busy_reg && (cnt_reg == WAIT_CYCLES - 16'h0001))
    else $error("wait ended before the full count");
  AST_WAIT_STEP: assert property (
    busy_reg && !wif.done && !wif.abort && !wif.start |=>
      busy_reg && (cnt_reg == $past(cnt_reg) + 16'h0001))
    else $error("wait counter skipped or stalled");
  AST_WAIT_FROM_ZERO: assert property (
    (wif.start && !wif.abort) |=> busy_reg && (cnt_reg == '0))
    else $error("wait did not restart from zero");
endmodule

// *** core/shhrc_wait_if.sv ***
/*
  Handshake between the standby controller and its release wait counter.
  Assumes both ends run on the same clock and reset.
*/
interface shhrc_wait_if;
  logic start;
  logic abort;
  logic busy;
  logic done;

  modport ctl (output start, output abort, input busy, input done);
  modport cnt (input start, input abort, output busy, output done);
endinterface

// *** dv/shhrc_board.sv ***
/*
  Board supervisor model: drives the standby and reset pins.
  Assumes the bench calls its tasks; pins change at rising ref_clk.
*/
module shhrc_board (
  input  wire logic ref_clk,
  output logic      standby_control_pin,
  output logic      reset_input_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Standby pin high at power-up so the reset pin can work
  initial begin
    standby_control_pin = 1'b1;
    reset_input_pin_n   = 1'b1;
  end
  // Raising the pin is the only wake source
  task set_standby(input logic v);
    @(posedge ref_clk);
    standby_control_pin <= v;
  endtask
  task set_reset_n(input logic v);
    @(posedge ref_clk);
    reset_input_pin_n <= v;
  endtask
endmodule

// *** dv/standby_hold_halt_reset_control_bench.sv ***
/*
  Self-checking bench for the standby and reset controller.
  Assumes a short hold wait parameter and the board model beside it.
*/
module standby_hold_halt_reset_control_bench;
  import shhrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HW = 16;
  logic ref_clk = 1'b0, arst_n, hold_instr, halt_instr;
  logic [PORT_W-1:0] halt_release_en, halt_release_port_bits;
  logic [P3_IN_W-1:0] port3_pins;
  logic [NUM_RST_PORTS-1:0] port_wr_en, port_oe_n;
  logic [NUM_RST_PORTS-1:0][PORT_W-1:0] port_wr_data, port_out;
  logic [INV_NUM-1:0] inv_in, inv_out, inv_oe_n;
  logic cpu_reset, cpu_run, osc_run, hold_active, halt_active, timer0_load;
  logic standby_control_pin, reset_input_pin_n, ld;
  logic [T0_W-1:0] timer0_value;
  logic [PORT_W-1:0] port3_read;
  int fail_count = 0, n_checks = 0, cycles = 0, k;
  always #2.5 ref_clk = ~ref_clk;
  shhrc_board shhrc_board_i (.ref_clk(ref_clk),
    .standby_control_pin(standby_control_pin),
    .reset_input_pin_n(reset_input_pin_n));
  shhrc_top #(.PORT_RST_LVL(3'h5), .HOLD_WAIT(16'h0010)) shhrc_top_i (
    .ref_clk(ref_clk), .arst_n(arst_n),
    .reset_input_pin_n(reset_input_pin_n),
    .standby_control_pin(standby_control_pin), .hold_instr(hold_instr),
    .halt_instr(halt_instr), .halt_release_en(halt_release_en),
    .halt_release_port_bits(halt_release_port_bits),
    .port3_pins(port3_pins), .port_wr_en(port_wr_en),
    .port_wr_data(port_wr_data), .inv_in(inv_in), .cpu_reset(cpu_reset),
    .cpu_run(cpu_run), .osc_run(osc_run), .hold_active(hold_active),
    .halt_active(halt_active), .timer0_load(timer0_load),
    .timer0_value(timer0_value), .port3_read(port3_read),
    .port_out(port_out), .port_oe_n(port_oe_n), .inv_out(inv_out),
    .inv_oe_n(inv_oe_n));
  task wrap_up;
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ceiling well above the hundred or so cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up;
    end
  end
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr(input int p, input logic [PORT_W-1:0] d);
    @(posedge ref_clk);
    port_wr_en[p] <= 1'b1;
    port_wr_data[p] <= d;
    @(posedge ref_clk);
    port_wr_en <= '0;
  endtask
  task pulse_hold;
    @(posedge ref_clk);
    hold_instr <= 1'b1;
    @(posedge ref_clk);
    hold_instr <= 1'b0;
  endtask
  task pulse_halt;
    @(posedge ref_clk);
    halt_instr <= 1'b1;
    @(posedge ref_clk);
    halt_instr <= 1'b0;
  endtask
  task t_reset_state;
    chk(port_out === {4'hF, 4'h0, 4'hF}, "reset levels");
    chk(port_oe_n === 3'h0 && cpu_run === 1'b1, "run after reset");
    chk(timer0_value === 12'hFFC, "timer0 value");
  endtask
  task t_pin_reset;
    wr(1, 4'hA);
    wr(2, 4'h3);
    cyc(2);
    chk(port_out[1] === 4'hA, "port write");
    chk(port_out[2] === 4'h3, "port 4 write");
    shhrc_board_i.set_reset_n(1'b0);
    cyc(3);
    chk(cpu_reset === 1'b1 && timer0_load === 1'b1, "pin reset");
    chk(cpu_run === 1'b0 && port_out[1] === 4'h0, "mask level");
    chk(port_out[2] === 4'hF, "port 4 mask level");
    shhrc_board_i.set_reset_n(1'b1);
    cyc(4);
    chk(cpu_reset === 1'b0 && cpu_run === 1'b1, "reset exit");
  endtask
  task t_hold;
    pulse_hold;
    cyc(2);
    chk(hold_active === 1'b0, "hold with pin high");
    shhrc_board_i.set_standby(1'b0);
    pulse_hold;
    cyc(2);
    chk(hold_active === 1'b1 && osc_run === 1'b0, "hold entry");
    chk(port_oe_n === 3'h7 && cpu_run === 1'b0, "ports off");
    chk(inv_oe_n === 2'h3 && inv_out === 2'h0, "inverters off");
    wr(0, 4'h9);
    shhrc_board_i.set_reset_n(1'b0);
    cyc(3);
    chk(cpu_reset === 1'b0 && hold_active === 1'b1, "reset blocked");
    shhrc_board_i.set_reset_n(1'b1);
    shhrc_board_i.set_standby(1'b1);
    ld = 1'b0;
    k = 0;
    while (cpu_run !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
      if (timer0_load === 1'b1) ld = 1'b1;
    end
    chk(k >= HW && k <= HW + 4, "release wait length");
    chk(ld === 1'b1 && port_oe_n === 3'h0, "timer0 load on wake");
    chk(hold_active === 1'b0 && port_out[0] === 4'hF, "hold left");
  endtask
  task t_halt;
    wr(0, 4'h6);
    for (int i = 0; i < PORT_W; i++) begin
      halt_release_en <= 4'h1 << i;
      pulse_halt;
      cyc(2);
      chk(halt_active === 1'b1 && osc_run === 1'b1, "halt entry");
      chk(port_out[0] === 4'h6 && port_oe_n === 3'h0, "halt keeps");
      @(posedge ref_clk);
      inv_in <= i[1:0];
      halt_release_port_bits <= ~(4'h1 << i);
      cyc(3);
      chk(halt_active === 1'b1, "other bits ignored");
      chk(inv_out === ~i[1:0] && inv_oe_n === 2'h0, "inverter runs");
      @(posedge ref_clk);
      halt_release_port_bits <= 4'hF;
      cyc(3);
      chk(halt_active === 1'b0 && cpu_run === 1'b1, "halt release");
      @(posedge ref_clk);
      halt_release_port_bits <= 4'h0;
    end
  endtask
  task t_port3;
    @(posedge ref_clk);
    port3_pins <= 3'h5;
    cyc(3);
    chk(port3_read === 4'hD, "port3 read");
  endtask
  initial begin
    arst_n <= 1'b0;
    hold_instr <= 1'b0;
    halt_instr <= 1'b0;
    halt_release_en <= '0;
    halt_release_port_bits <= '0;
    port3_pins <= '0;
    port_wr_en <= '0;
    port_wr_data <= '0;
    inv_in <= '0;
    cyc(10);
    arst_n <= 1'b1;
    cyc(5);
    t_reset_state;
    t_pin_reset;
    t_hold;
    t_halt;
    t_port3;
    wrap_up;
  end
endmodule
